// [adc_config_register_bank.sv]
// Converter configuration register bank: identity, scratch, loop depth, copy, options
//
// Functional notes
// [R1] Scratch byte reads back as written, reset zero
// [R2] Silicon revision byte is read-only constant
// [R3] Serial protocol revision byte is read-only
// [R4] Maker code split low then high byte
// [R5] Loop depth byte read/write, reset zero
// [R6] Trigger bit copies master bytes into slaves
// [R7] Trigger bit clears itself after the copy
// [R8] Readback shows slave unless master select set
// [R9] Chip select rising edge also starts copy
// [R10] Option bit 3 picks antialias mode
// [R11] Option bit 2 picks serial out source
// [R12] Option bit 1 enables reference gain fix
// [R13] Option bit 0 enables crystal clock output
// [R14] Option bits 7 to 4 read zero
// [R15] Writes to read-only or reserved bits ignored
`timescale 1ns/1ps
`default_nettype none

module adc_config_register_bank #(
    parameter logic [7:0]  DIE_REVISION_VALUE        = 8'h11,   // Arbitrary value
    parameter logic [7:0]  SERIAL_PROTOCOL_REV_VALUE = 8'h13,   // Arbitrary value
    parameter logic [15:0] MAKER_CODE                = 16'h3a5c, // Arbitrary value
    parameter int          NBUF                      = 8,
    parameter int          IW                        = (NBUF > 1) ? $clog2(NBUF) : 1
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_rd,
    output var  logic [7:0]        reg_rdata,
    input  wire logic              cs_n_pin,
    input  wire logic              master_slave_rd_ctrl,
    input  wire logic [8*NBUF-1:0] master_in,
    input  wire logic [IW-1:0]     buf_rd_index,
    output var  logic [7:0]        buf_rd_data,
    output var  logic [8*NBUF-1:0] slave_out,
    input  wire logic              conversion_lane_zero,
    input  wire logic              spi_readback_bit,
    input  wire logic              crystal_clock_src,
    output var  logic              shared_serial_out_pin,
    output var  logic              crystal_clock_out_pin,
    output var  logic              antialias_select,
    output var  logic              serial_out_source_select,
    output var  logic              ref_gain_fix_enable,
    output var  logic              crystal_out_enable,
    output var  logic [7:0]        address_loop_depth
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0]                    scratch_q;
    logic [7:0]                    scratch_d;
    logic [7:0]                    loop_depth_q;
    logic [7:0]                    loop_depth_d;
    logic                          trigger_q;
    logic                          trigger_d;
    logic [3:0]                    options_q;
    logic [3:0]                    options_d;
    logic [7:0]                    rdata_q;
    logic [7:0]                    rdata_d;
    logic                          sdo_q;
    logic                          sdo_d;
    logic                          xclk_q;
    logic                          xclk_d;
    adc_cfg_pkg::copy_state_t      state_q;
    adc_cfg_pkg::copy_state_t      state_d;
    logic                          req_q;
    logic                          req_d;
    logic                          cs_rise;
    logic                          trig_wr;
    logic                          rearm_q;
    logic                          rearm_d;
    logic                          wr_scratch;
    logic                          wr_depth;
    logic                          wr_options;

    copy_if cp ();

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    cs_rise_detect u_cs (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .cs_n_pin (cs_n_pin),
        .cs_rise  (cs_rise)
    );

    buffer_store #(
        .NBUF (NBUF),
        .IW   (IW)
    ) u_store (
        .sys_clk       (sys_clk),
        .srst          (srst),
        .cp            (cp.store),
        .master_in     (master_in),
        .rd_master_sel (master_slave_rd_ctrl),
        .rd_index      (buf_rd_index),
        .slave_out     (slave_out),
        .buf_rd_data   (buf_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    assign wr_scratch = reg_wr && hit(reg_addr, adc_cfg_pkg::OFF_TEST_BYTE_STORE);
    assign wr_depth   = reg_wr && hit(reg_addr, adc_cfg_pkg::OFF_ADDRESS_LOOP_DEPTH);
    assign wr_options = reg_wr && hit(reg_addr, adc_cfg_pkg::OFF_CONVERTER_OPTIONS);

    ////////////////////////////////////////////////////////////////////////
    // Writable registers
    always_comb begin
        scratch_d    = scratch_q;
        loop_depth_d = loop_depth_q;
        options_d    = options_q;
        if (wr_scratch) begin
            scratch_d = reg_wdata; // see [R1]
        end
        if (wr_depth) begin
            loop_depth_d = reg_wdata; // see [R5]
        end
        if (wr_options) begin
            options_d = reg_wdata[adc_cfg_pkg::OPTIONS_USED_BITS-1:0]; // see [R14] see [R15]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            scratch_q    <= adc_cfg_pkg::RST_TEST_BYTE_STORE;
            loop_depth_q <= adc_cfg_pkg::RST_ADDRESS_LOOP_DEPTH;
            options_q    <= adc_cfg_pkg::RST_CONVERTER_OPTIONS[3:0];
        end else begin
            scratch_q    <= scratch_d;
            loop_depth_q <= loop_depth_d;
            options_q    <= options_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Copy trigger and sequencer
    assign trig_wr = reg_wr && hit(reg_addr, adc_cfg_pkg::OFF_BUFFER_COPY_TRIGGER)
                     && reg_wdata[adc_cfg_pkg::COPY_TRIGGER_BIT];

    always_comb begin
        state_d   = state_q;
        req_d     = 1'b0;
        trigger_d = trigger_q;
        rearm_d   = rearm_q;
        case (state_q)
            adc_cfg_pkg::COPY_IDLE: begin
                if (trigger_q) begin
                    req_d   = 1'b1; // see [R6]
                    state_d = adc_cfg_pkg::COPY_WAIT;
                end
            end
            adc_cfg_pkg::COPY_WAIT: begin
                if (cp.copy_done) begin
                    trigger_d = rearm_q; // see [R7]
                    rearm_d   = 1'b0;
                    state_d   = adc_cfg_pkg::COPY_IDLE;
                end else if (trig_wr || cs_rise) begin
                    rearm_d = 1'b1; // see [R6] see [R9]
                end
            end
            default: begin
                state_d = adc_cfg_pkg::COPY_IDLE;
            end
        endcase
        if (trig_wr || cs_rise) begin
            trigger_d = 1'b1; // see [R6] see [R9]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q   <= adc_cfg_pkg::COPY_IDLE;
            req_q     <= 1'b0;
            trigger_q <= adc_cfg_pkg::RST_BUFFER_COPY_TRIGGER[0];
            rearm_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            req_q     <= req_d;
            trigger_q <= trigger_d;
            rearm_q   <= rearm_d;
        end
    end

    assign cp.copy_req = req_q;

    ////////////////////////////////////////////////////////////////////////
    // Register readback
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                adc_cfg_pkg::OFF_SILICON_REVISION: begin
                    rdata_d = DIE_REVISION_VALUE; // see [R2]
                end
                adc_cfg_pkg::OFF_TEST_BYTE_STORE: begin
                    rdata_d = scratch_q; // see [R1]
                end
                adc_cfg_pkg::OFF_SERIAL_PROTOCOL_REVISION: begin
                    rdata_d = SERIAL_PROTOCOL_REV_VALUE; // see [R3]
                end
                adc_cfg_pkg::OFF_MAKER_CODE_LOW: begin
                    rdata_d = MAKER_CODE[7:0]; // see [R4]
                end
                adc_cfg_pkg::OFF_MAKER_CODE_HIGH: begin
                    rdata_d = MAKER_CODE[15:8]; // see [R4]
                end
                adc_cfg_pkg::OFF_ADDRESS_LOOP_DEPTH: begin
                    rdata_d = loop_depth_q; // see [R5]
                end
                adc_cfg_pkg::OFF_BUFFER_COPY_TRIGGER: begin
                    rdata_d = {7'h00, trigger_q}; // see [R7]
                end
                adc_cfg_pkg::OFF_CONVERTER_OPTIONS: begin
                    rdata_d = {4'h0, options_q}; // see [R14]
                end
                default: begin
                    rdata_d = adc_cfg_pkg::UNMAPPED_READ_DATA;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_q <= adc_cfg_pkg::RST_READ_DATA;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs
    always_comb begin
        sdo_d  = options_q[adc_cfg_pkg::OUT_SOURCE_BIT] ? conversion_lane_zero
                                                        : spi_readback_bit; // see [R11]
        xclk_d = options_q[adc_cfg_pkg::CRYSTAL_OUT_BIT] & crystal_clock_src; // see [R13]
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sdo_q   <= 1'b0;
            xclk_q  <= 1'b0;
        end else begin
            sdo_q   <= sdo_d;
            xclk_q  <= xclk_d;
        end
    end

    assign reg_rdata                = rdata_q;
    assign shared_serial_out_pin    = sdo_q;
    assign crystal_clock_out_pin    = xclk_q;
    assign antialias_select         = options_q[adc_cfg_pkg::ANTIALIAS_SELECT_BIT]; // see [R10]
    assign serial_out_source_select = options_q[adc_cfg_pkg::OUT_SOURCE_BIT]; // see [R11]
    assign ref_gain_fix_enable      = options_q[adc_cfg_pkg::REF_GAIN_FIX_BIT]; // see [R12]
    assign crystal_out_enable       = options_q[adc_cfg_pkg::CRYSTAL_OUT_BIT]; // see [R13]
    assign address_loop_depth       = loop_depth_q; // see [R5]

endmodule

`default_nettype wire

// [adc_cfg_pkg.sv]
// Constants shared by the converter configuration register bank
package adc_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFF_SILICON_REVISION         = 8'h07;
    localparam logic [7:0] OFF_TEST_BYTE_STORE          = 8'h0a;
    localparam logic [7:0] OFF_SERIAL_PROTOCOL_REVISION = 8'h0b;
    localparam logic [7:0] OFF_MAKER_CODE_LOW           = 8'h0c;
    localparam logic [7:0] OFF_MAKER_CODE_HIGH          = 8'h0d;
    localparam logic [7:0] OFF_ADDRESS_LOOP_DEPTH       = 8'h0e;
    localparam logic [7:0] OFF_BUFFER_COPY_TRIGGER      = 8'h0f;
    localparam logic [7:0] OFF_CONVERTER_OPTIONS        = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int COPY_TRIGGER_BIT     = 0;
    localparam int ANTIALIAS_SELECT_BIT = 3;
    localparam int OUT_SOURCE_BIT       = 2;
    localparam int REF_GAIN_FIX_BIT     = 1;
    localparam int CRYSTAL_OUT_BIT      = 0;
    localparam int OPTIONS_USED_BITS    = 4;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_TEST_BYTE_STORE     = 8'h00;
    localparam logic [7:0] RST_ADDRESS_LOOP_DEPTH  = 8'h00;
    localparam logic [7:0] RST_BUFFER_COPY_TRIGGER = 8'h00;
    localparam logic [7:0] RST_CONVERTER_OPTIONS   = 8'h00;
    localparam logic [7:0] RST_READ_DATA           = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_DATA      = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Copy sequencer states
    typedef enum logic [0:0] {
        COPY_IDLE = 1'b0,
        COPY_WAIT = 1'b1
    } copy_state_t;

endpackage

// [copy_if.sv]
// Handshake between the copy sequencer and the buffered slave store
`timescale 1ns/1ps
`default_nettype none

interface copy_if;
    logic copy_req;
    logic copy_done;

    modport ctrl  (output copy_req, input copy_done);
    modport store (input copy_req, output copy_done);
endinterface

`default_nettype wire

// [cs_rise_detect.sv]
// Chip select synchroniser and rising edge pulse
`timescale 1ns/1ps
`default_nettype none

module cs_rise_detect (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic cs_n_pin,
    output var  logic cs_rise
);

    logic meta_q;
    logic sync_q;
    logic last_q;
    logic rise_q;
    logic rise_d;

    ////////////////////////////////////////////////////////////////////////
    // Edge decode on the synchronised level
    always_comb begin
        rise_d = sync_q & ~last_q;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
            rise_q <= 1'b0;
        end else begin
            meta_q <= cs_n_pin;
            sync_q <= meta_q;
            last_q <= sync_q;
            rise_q <= rise_d;
        end
    end

    assign cs_rise = rise_q;

endmodule

`default_nettype wire

// [buffer_store.sv]
// Slave copies of the buffered master bytes and their readback
`timescale 1ns/1ps
`default_nettype none

module buffer_store #(
    parameter int NBUF = 8,
    parameter int IW   = (NBUF > 1) ? $clog2(NBUF) : 1
) (
    input  wire logic            sys_clk,
    input  wire logic            srst,
    copy_if.store                cp,
    input  wire logic [8*NBUF-1:0] master_in,
    input  wire logic            rd_master_sel,
    input  wire logic [IW-1:0]   rd_index,
    output var  logic [8*NBUF-1:0] slave_out,
    output var  logic [7:0]      buf_rd_data
);

    logic [7:0] slave_q [NBUF];
    logic [7:0] slave_d [NBUF];
    logic       done_q;
    logic       done_d;
    logic [7:0] rd_q;
    logic [7:0] rd_d;

    ////////////////////////////////////////////////////////////////////////
    // Copy and readback select
    always_comb begin
        done_d = cp.copy_req;
        for (int i = 0; i < NBUF; i++) begin
            slave_d[i] = cp.copy_req ? master_in[8*i +: 8] : slave_q[i]; // see [R6]
        end
        rd_d = slave_q[0];
        for (int i = 0; i < NBUF; i++) begin
            if (rd_index == IW'(i)) begin
                rd_d = rd_master_sel ? master_in[8*i +: 8] : slave_q[i]; // see [R8]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < NBUF; i++) begin
                slave_q[i] <= 8'h00;
            end
            done_q <= 1'b0;
            rd_q   <= 8'h00;
        end else begin
            slave_q <= slave_d;
            done_q  <= done_d;
            rd_q    <= rd_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NBUF; g++) begin : g_out
            assign slave_out[8*g +: 8] = slave_q[g];
        end
    endgenerate

    assign cp.copy_done  = done_q;
    assign buf_rd_data   = rd_q;

endmodule

`default_nettype wire

// [adc_cfg_props.sv]
// Checker for the converter configuration register bank
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_props #(
    parameter logic [15:0] MAKER_CODE = 16'h0000,
    parameter int          NBUF       = 8
) (
    input wire logic            sys_clk,
    input wire logic            srst,
    input wire logic [7:0]      reg_addr,
    input wire logic            reg_wr,
    input wire logic [7:0]      reg_wdata,
    input wire logic            reg_rd,
    input wire logic [7:0]      reg_rdata,
    input wire logic [8*NBUF-1:0] master_in,
    input wire logic [8*NBUF-1:0] slave_out,
    input wire logic            conversion_lane_zero,
    input wire logic            spi_readback_bit,
    input wire logic            crystal_clock_src,
    input wire logic            shared_serial_out_pin,
    input wire logic            crystal_clock_out_pin,
    input wire logic            antialias_select,
    input wire logic            serial_out_source_select,
    input wire logic            crystal_out_enable,
    input wire logic [7:0]      address_loop_depth
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire wr_scr = reg_wr && reg_addr == adc_cfg_pkg::OFF_TEST_BYTE_STORE;
    wire rd_scr = reg_rd && !reg_wr && reg_addr == adc_cfg_pkg::OFF_TEST_BYTE_STORE;
    wire wr_opt = reg_wr && reg_addr == adc_cfg_pkg::OFF_CONVERTER_OPTIONS;
    wire rd_opt = reg_rd && reg_addr == adc_cfg_pkg::OFF_CONVERTER_OPTIONS;
    wire trig_wr = reg_wr && reg_addr == adc_cfg_pkg::OFF_BUFFER_COPY_TRIGGER && reg_wdata[0];
    wire wr_depth = reg_wr && reg_addr == adc_cfg_pkg::OFF_ADDRESS_LOOP_DEPTH;
    ////////////////////////////////////////////////////////////////////////
    a_scratch_readback: assert property ((wr_scr ##1 !reg_wr ##1 rd_scr) |=>
        reg_rdata == $past(reg_wdata, 3)) else $error("scratch readback wrong");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_maker_low: assert property (reg_rd && reg_addr == adc_cfg_pkg::OFF_MAKER_CODE_LOW
        |=> reg_rdata == MAKER_CODE[7:0]) else $error("maker code low byte wrong");
    a_opt_reserved: assert property (rd_opt |=> reg_rdata[7:4] == 4'h0)
        else $error("option reserved bits not zero");
    a_depth_write: assert property (wr_depth |=>
        address_loop_depth == $past(reg_wdata)) else $error("loop depth not stored");
    a_option_write: assert property (wr_opt |=>
        antialias_select == $past(reg_wdata[3]) && crystal_out_enable == $past(reg_wdata[0]))
        else $error("option bits wrong");
    a_copy_lands: assert property (trig_wr |-> ##[1:6] slave_out == master_in)
        else $error("copy did not land");
    a_pin_source: assert property (!$past(srst) |-> shared_serial_out_pin ==
        $past(serial_out_source_select ? conversion_lane_zero : spi_readback_bit))
        else $error("serial out source wrong");
    a_crystal_gate: assert property (!$past(srst) |-> crystal_clock_out_pin ==
        $past(crystal_out_enable && crystal_clock_src)) else $error("crystal out gate wrong");
    c_copy: cover property (trig_wr);
    c_opt_read: cover property (rd_opt);
    c_scratch: cover property (wr_scr ##2 rd_scr);
endmodule
bind adc_config_register_bank adc_cfg_props #(.MAKER_CODE(MAKER_CODE), .NBUF(NBUF)) chk (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_in(master_in),
    .slave_out(slave_out), .conversion_lane_zero(conversion_lane_zero),
    .spi_readback_bit(spi_readback_bit), .crystal_clock_src(crystal_clock_src),
    .shared_serial_out_pin(shared_serial_out_pin), .crystal_clock_out_pin(crystal_clock_out_pin),
    .antialias_select(antialias_select), .serial_out_source_select(serial_out_source_select),
    .crystal_out_enable(crystal_out_enable), .address_loop_depth(address_loop_depth));
`default_nettype wire

// [spi_host_model.sv]
// Host side model driving chip select frames
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic sys_clk,
    output var  logic cs_n_pin
);
    initial cs_n_pin = 1'b1;
    // Low for n cycles, then rise
    task automatic frame(input int n);
        @(posedge sys_clk);
        #1 cs_n_pin = 1'b0;
        repeat (n) @(posedge sys_clk);
        #1 cs_n_pin = 1'b1;
    endtask
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the converter configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); err_total++; end end
module tb;
    localparam logic [7:0]  DIE = 8'h31;    // Arbitrary value
    localparam logic [7:0]  SER = 8'h35;    // Arbitrary value
    localparam logic [15:0] MKR = 16'h9c6e; // Arbitrary value
    logic        sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, ctrl = 0;
    logic        lane = 0, spib = 0, xsrc = 0, cs_n_pin, aa, src, gain, xen;
    logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, buf_rd_data, depth, d;
    logic [63:0] master_in = 0, slave_out, exp_slv = 0;
    logic [2:0]  idx = 0;
    int          seed = 32'h6a76, pin_seed = 32'h6a76, err_total = 0, compares = 0, k, r;
    logic [7:0]  addrs [8] = '{8'h07, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
    logic [7:0]  rst_v [8] = '{DIE, 8'h00, SER, MKR[7:0], MKR[15:8], 8'h00, 8'h00, 8'h00};
    adc_config_register_bank #(.DIE_REVISION_VALUE(DIE), .SERIAL_PROTOCOL_REV_VALUE(SER),
        .MAKER_CODE(MKR), .NBUF(8)) uut (
        .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cs_n_pin(cs_n_pin),
        .master_slave_rd_ctrl(ctrl), .master_in(master_in), .buf_rd_index(idx),
        .buf_rd_data(buf_rd_data), .slave_out(slave_out), .conversion_lane_zero(lane),
        .spi_readback_bit(spib), .crystal_clock_src(xsrc), .shared_serial_out_pin(),
        .crystal_clock_out_pin(), .antialias_select(aa), .serial_out_source_select(src),
        .ref_gain_fix_enable(gain), .crystal_out_enable(xen), .address_loop_depth(depth));
    spi_host_model host (.sys_clk(sys_clk), .cs_n_pin(cs_n_pin));
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        #1 {lane, spib, xsrc} = 3'($random(pin_seed));
    end
    ////////////////////////////////////////////////////////////////////////
    // Expected readback after a write of v to table entry i
    function automatic logic [7:0] exp_wr(input int i, input logic [7:0] v);
        if (i == 1 || i == 5) return v;
        if (i == 7) return {4'h0, v[3:0]};
        return rst_v[i];
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        cyc(1);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        cyc(1);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
    endtask
    task automatic finish_test;
        if (err_total == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(16);
        srst = 1'b0;
        for (k = 0; k < 8; k++) begin
            rd(addrs[k]);
            `CHK(reg_rdata, rst_v[k])
        end
        for (r = 0; r < 4; r++) begin
            for (k = 0; k < 8; k++) begin
                if (k == 6) continue;
                d = (r == 0) ? 8'hff : 8'($random(seed));
                wr(addrs[k], d);
                rd(addrs[k]);
                `CHK(reg_rdata, exp_wr(k, d))
                if (k == 5) `CHK(depth, d)
                if (k == 7) `CHK({aa, src, gain, xen}, d[3:0])
            end
        end
        wr(8'h08, 8'h5a);
        rd(8'h08);
        `CHK(reg_rdata, 8'h00)
        for (r = 0; r < 3; r++) begin
            master_in = {$random(seed), $random(seed)};
            idx = 3'($random(seed));
            ctrl = 1'b0;
            cyc(2);
            `CHK(buf_rd_data, exp_slv[8*idx+:8])
            ctrl = 1'b1;
            cyc(2);
            `CHK(buf_rd_data, master_in[8*idx+:8])
            ctrl = 1'b0;
            wr(8'h0f, 8'hfe);
            cyc(5);
            `CHK(slave_out, exp_slv)
            if (r == 2) begin
                host.frame(4);
                for (k = 0; k < 12 && slave_out !== master_in; k++) cyc(1);
            end else begin
                wr(8'h0f, 8'h01);
                rd(8'h0f);
                `CHK(reg_rdata, 8'h01)
                for (k = 0; k < 10 && reg_rdata !== 8'h00; k++) rd(8'h0f);
                `CHK(reg_rdata, 8'h00)
            end
            `CHK(slave_out, master_in)
            exp_slv = master_in;
            cyc(2);
            `CHK(buf_rd_data, exp_slv[8*idx+:8])
        end
        finish_test();
    end
endmodule
`default_nettype wire
